/* pfc_pkg.sv */
package pfc_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned OFF_W     = 12;
  localparam int unsigned STRAP_W   = 5;
  localparam int unsigned PAUSE_HI_W = 16;

  localparam logic [OFF_W-1:0] FC1_OFF      = 12'h1a0;
  localparam logic [OFF_W-1:0] PAUSE_HI_OFF = 12'h1b0;
  localparam logic [OFF_W-1:0] PAUSE_LO_OFF = 12'h1b4;

  localparam int unsigned BP_BIT  = 6;
  localparam int unsigned DUP_BIT = 5;
  localparam int unsigned CRX_BIT = 4;
  localparam int unsigned CTX_BIT = 3;
  localparam int unsigned RXE_BIT = 2;
  localparam int unsigned TXE_BIT = 1;
  localparam int unsigned MAN_BIT = 0;
  localparam int unsigned RSV_LO  = 7;

  localparam logic [PAUSE_HI_W-1:0] PAUSE_HI_RST = 16'h0000;
  localparam logic [DATA_W-1:0]     PAUSE_LO_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0]     RDATA_RST    = 32'h0000_0000;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  typedef struct packed {
    logic backpressure;
    logic fd_pause;
    logic manual;
    logic half_duplex;
    logic autoneg;
  } pfc_strap_s;

  typedef struct packed {
    logic backpressure;
    logic rx_en;
    logic tx_en;
    logic manual;
  } pfc_cfg_s;

  typedef struct packed {
    logic half_duplex;
    logic rx_act;
    logic tx_act;
  } pfc_status_s;

  typedef enum logic [1:0] {
    INIT_SYNC0,
    INIT_SYNC1,
    INIT_LOAD,
    INIT_RUN
  } pfc_init_e;

endpackage

/* pfc_resolve.sv */
module pfc_resolve (
  input  wire pfc_pkg::pfc_cfg_s cfg,
  input  wire logic              half_duplex,
  input  wire logic              an_enable,
  input  wire logic              neg_rx,
  input  wire logic              neg_tx,
  output logic                   rx_act,
  output logic                   tx_act
);
  import pfc_pkg::*;

  logic use_manual;

  // Manual enables apply when manual select is set or negotiation is off.
  assign use_manual = cfg.manual || !an_enable;

  // Pause flow control exists only in full duplex.
  assign rx_act = !half_duplex && (use_manual ? cfg.rx_en : neg_rx);
  assign tx_act = !half_duplex && (use_manual ? cfg.tx_en : neg_tx);

endmodule // pfc_resolve

/* pfc_top.sv */
// Notes on behaviour
// - Bit 6 is read/write and turns half-duplex backpressure on port 1 on.
// - Read-only bit 5 shows the duplex in use, 0 full and 1 half.
// - Read-only bit 4 shows whether receive pause is active on port 1.
// - Read-only bit 3 shows whether transmit pause is active on port 1.
// - The status bits follow the settings in effect, manual or negotiated.
// - Bit 2 enables pause detection when manual or negotiation is off.
// - Bit 1 enables pause generation when manual or negotiation is off.
// - With manual clear and negotiation on, the negotiated result rules.
// - With manual set, bits 2 and 1 rule flow control in full duplex.
// - Writable bits load from straps at reset and on each loader rewrite.
// - Status bits at reset come from several straps combined.
// - Writes here never alter the transceiver advertisement values.
// - Pause frame source address comes from two dedicated registers.
//
// Implementation choice: register access over AHB-Lite.
module pfc_top (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire pfc_pkg::pfc_strap_s strap_pins,
  input  wire logic                eeprom_load,
  input  wire pfc_pkg::pfc_strap_s eeprom_straps,
  input  wire logic                phy_link_up,
  input  wire logic                phy_half_duplex,
  input  wire logic                phy_an_enable,
  input  wire logic                phy_an_rx_pause,
  input  wire logic                phy_an_tx_pause,
  output logic                     p1_backpressure_enable,
  output logic                     p1_rx_pause_active,
  output logic                     p1_tx_pause_active,
  output logic                     p1_half_duplex,
  output logic      [47:0]         pause_src_addr
);
  import pfc_pkg::*;

  logic [STRAP_W-1:0]    sync1_q;
  logic [STRAP_W-1:0]    sync2_q;
  pfc_init_e             init_q;
  pfc_strap_s            strap_q;
  pfc_strap_s            load_src;
  logic                  load_cfg;
  pfc_cfg_s              cfg_q;
  pfc_status_s           status_q;
  logic                  eff_half;
  logic                  eff_an;
  logic                  rx_act;
  logic                  tx_act;
  logic                  addr_ph;
  logic                  wr_pend_q;
  logic                  rd_pend_q;
  logic [OFF_W-1:0]      addr_q;
  logic                  wr_fc;
  logic [PAUSE_HI_W-1:0] pause_hi_q;
  logic [DATA_W-1:0]     pause_lo_q;
  logic [DATA_W-1:0]     rd_mux;
  logic [DATA_W-1:0]     hrdata_q;
  logic                  hreadyout_q;
  logic                  hresp_q;

  // Strap pins pass two flip-flops before anything reads them.
  for (genvar i = 0; i < STRAP_W; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= strap_pins[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // Sequencer that lets the synchroniser fill before straps are taken.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_q <= INIT_SYNC0;
    end else begin
      case (init_q)
        INIT_SYNC0: init_q <= INIT_SYNC1;
        INIT_SYNC1: init_q <= INIT_LOAD;
        INIT_LOAD:  init_q <= INIT_RUN;
        INIT_RUN:   init_q <= INIT_RUN;
        default:    init_q <= INIT_RUN;
      endcase
    end
  end

  // Strap values come from the pins once, then from the loader.
  always_comb begin
    load_cfg = (init_q == INIT_LOAD) || eeprom_load;
    load_src = (init_q == INIT_LOAD) ? pfc_strap_s'(sync2_q) : eeprom_straps;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_q <= '0;
    end else if (load_cfg) begin
      strap_q <= load_src;
    end
  end

  // Bus decode; only whole-word writes are accepted.
  assign addr_ph = hsel && htrans[1] && hready;
  assign wr_fc   = wr_pend_q && (addr_q == FC1_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= '0;
    end else begin
      wr_pend_q <= addr_ph && hwrite && (hsize == HSIZE_WORD);
      rd_pend_q <= addr_ph && !hwrite;
      if (addr_ph) begin
        addr_q <= haddr[OFF_W-1:0];
      end
    end
  end

  // Writable configuration; a loader rewrite beats a bus write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= '0;
    end else if (load_cfg) begin
      cfg_q.backpressure <= load_src.backpressure;
      cfg_q.rx_en        <= load_src.fd_pause;
      cfg_q.tx_en        <= load_src.fd_pause;
      cfg_q.manual       <= load_src.manual;
    end else if (wr_fc) begin
      // Only the four writable bits are taken; nothing leaves the block
      // toward the transceiver advertisement.
      cfg_q.backpressure <= hwdata[BP_BIT];
      cfg_q.rx_en        <= hwdata[RXE_BIT];
      cfg_q.tx_en        <= hwdata[TXE_BIT];
      cfg_q.manual       <= hwdata[MAN_BIT];
    end
  end

  // Live link state wins once the link is up; straps stand in before.
  always_comb begin
    eff_half = phy_link_up ? phy_half_duplex : strap_q.half_duplex;
    eff_an   = phy_link_up ? phy_an_enable : strap_q.autoneg;
  end

  pfc_resolve u_resolve (
    .cfg         (cfg_q),
    .half_duplex (eff_half),
    .an_enable   (eff_an),
    .neg_rx      (phy_an_rx_pause),
    .neg_tx      (phy_an_tx_pause),
    .rx_act      (rx_act),
    .tx_act      (tx_act)
  );

  // Status is recomputed every cycle from the settings in effect.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
    end else begin
      status_q.half_duplex <= eff_half;
      status_q.rx_act      <= rx_act;
      status_q.tx_act      <= tx_act;
    end
  end

  // Pause frame source address registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_hi_q <= PAUSE_HI_RST;
      pause_lo_q <= PAUSE_LO_RST;
    end else if (wr_pend_q) begin
      if (addr_q == PAUSE_HI_OFF) begin
        pause_hi_q <= hwdata[PAUSE_HI_W-1:0];
      end
      if (addr_q == PAUSE_LO_OFF) begin
        pause_lo_q <= hwdata;
      end
    end
  end

  // Read mux; reserved bits and unmapped words read as zero.
  always_comb begin
    rd_mux = '0;
    case (addr_q)
      FC1_OFF: begin
        rd_mux[BP_BIT]  = cfg_q.backpressure;
        rd_mux[DUP_BIT] = status_q.half_duplex;
        rd_mux[CRX_BIT] = status_q.rx_act;
        rd_mux[CTX_BIT] = status_q.tx_act;
        rd_mux[RXE_BIT] = cfg_q.rx_en;
        rd_mux[TXE_BIT] = cfg_q.tx_en;
        rd_mux[MAN_BIT] = cfg_q.manual;
      end
      PAUSE_HI_OFF: rd_mux[PAUSE_HI_W-1:0] = pause_hi_q;
      PAUSE_LO_OFF: rd_mux = pause_lo_q;
      default:      rd_mux = '0;
    endcase
  end

  // Reads take one wait state so the data leave a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= RDATA_RST;
      hresp_q     <= HRESP_OKAY;
    end else begin
      hresp_q <= HRESP_OKAY;
      if (addr_ph && !hwrite) begin
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout_q <= 1'b1;
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hrdata                 = hrdata_q;
  assign hreadyout              = hreadyout_q;
  assign hresp                  = hresp_q;
  assign p1_backpressure_enable = cfg_q.backpressure;
  assign p1_half_duplex         = status_q.half_duplex;
  assign p1_rx_pause_active     = status_q.rx_act;
  assign p1_tx_pause_active     = status_q.tx_act;
  assign pause_src_addr         = {pause_hi_q, pause_lo_q};

  property p_bp_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_fc && !load_cfg |=> cfg_q.backpressure == $past(hwdata[BP_BIT]);
  endproperty
  a_bp_write: assert property (p_bp_write)
    else $error("Backpressure bit did not take the written value.");

  property p_dup_status;
    @(posedge hclk) disable iff (!hresetn)
      init_q == INIT_RUN |=> p1_half_duplex == $past(eff_half);
  endproperty
  a_dup_status: assert property (p_dup_status)
    else $error("Duplex status does not follow the duplex in use.");

  property p_half_no_pause;
    @(posedge hclk) disable iff (!hresetn)
      eff_half |=> !p1_rx_pause_active && !p1_tx_pause_active;
  endproperty
  a_half_no_pause: assert property (p_half_no_pause)
    else $error("Pause active while in half duplex.");

  property p_manual_tx;
    @(posedge hclk) disable iff (!hresetn)
      cfg_q.manual && !eff_half |=> p1_tx_pause_active == $past(cfg_q.tx_en);
  endproperty
  a_manual_tx: assert property (p_manual_tx)
    else $error("Manual transmit pause not applied.");

  property p_auto_rx;
    @(posedge hclk) disable iff (!hresetn)
      !cfg_q.manual && eff_an && !eff_half
      |=> p1_rx_pause_active == $past(phy_an_rx_pause);
  endproperty
  a_auto_rx: assert property (p_auto_rx)
    else $error("Negotiated receive pause not applied.");

  property p_an_off_rx;
    @(posedge hclk) disable iff (!hresetn)
      !eff_an && !eff_half |=> p1_rx_pause_active == $past(cfg_q.rx_en);
  endproperty
  a_an_off_rx: assert property (p_an_off_rx)
    else $error("Receive enable ignored with negotiation off.");

  property p_eeprom;
    @(posedge hclk) disable iff (!hresetn)
      eeprom_load && init_q == INIT_RUN
      |=> cfg_q.rx_en == $past(eeprom_straps.fd_pause)
          && cfg_q.manual == $past(eeprom_straps.manual)
          && cfg_q.backpressure == $past(eeprom_straps.backpressure);
  endproperty
  a_eeprom: assert property (p_eeprom)
    else $error("Loader rewrite did not update the register.");

  property p_reset_status;
    @(posedge hclk) disable iff (!hresetn)
      init_q == INIT_LOAD ##1 (!phy_link_up && !eeprom_load)
      |=> p1_half_duplex == $past(strap_q.half_duplex);
  endproperty
  a_reset_status: assert property (p_reset_status)
    else $error("Duplex status after reset not taken from straps.");

  property p_reserved;
    @(posedge hclk) disable iff (!hresetn)
      $rose(hreadyout_q) && addr_q == FC1_OFF
      |-> hrdata_q[DATA_W-1:RSV_LO] == '0
          && hrdata_q[DUP_BIT] == $past(status_q.half_duplex);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits or duplex read back wrong.");

  property p_ro_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_fc |=> p1_half_duplex == $past(eff_half)
                && p1_tx_pause_active == $past(tx_act);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("A write reached a read-only status bit.");

  property p_pause_lo;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend_q && addr_q == PAUSE_LO_OFF
      |=> pause_src_addr[DATA_W-1:0] == $past(hwdata);
  endproperty
  a_pause_lo: assert property (p_pause_lo)
    else $error("Pause source address low word not written.");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
      $fell(hreadyout_q) |=> hreadyout_q;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("Read wait state lasted more than one cycle.");

  property p_an_off_tx;
    @(posedge hclk) disable iff (!hresetn)
      !eff_an && !eff_half |=> p1_tx_pause_active == $past(cfg_q.tx_en);
  endproperty
  a_an_off_tx: assert property (p_an_off_tx)
    else $error("Transmit enable ignored with negotiation off.");

  property p_auto_tx;
    @(posedge hclk) disable iff (!hresetn)
      !cfg_q.manual && eff_an && !eff_half
      |=> p1_tx_pause_active == $past(phy_an_tx_pause);
  endproperty
  a_auto_tx: assert property (p_auto_tx)
    else $error("Negotiated transmit pause not shown.");

  property p_tx_read;
    @(posedge hclk) disable iff (!hresetn)
      $rose(hreadyout_q) && addr_q == FC1_OFF
      |-> hrdata_q[CTX_BIT] == $past(status_q.tx_act)
          && hrdata_q[CRX_BIT] == $past(status_q.rx_act);
  endproperty
  a_tx_read: assert property (p_tx_read)
    else $error("Pause status bits read back wrong.");

endmodule // pfc_top

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_pkg::*;

  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = HSIZE_WORD;
  logic [31:0]       hwdata = 32'h0;
  wire logic         hready;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  pfc_strap_s        strap_pins = '0;
  logic              eeprom_load = 1'b0;
  pfc_strap_s        eeprom_straps = '0;
  logic              phy_link_up = 1'b0;
  logic              phy_half_duplex = 1'b0;
  logic              phy_an_enable = 1'b0;
  logic              phy_an_rx_pause = 1'b0;
  logic              phy_an_tx_pause = 1'b0;
  logic              p1_backpressure_enable;
  logic              p1_rx_pause_active;
  logic              p1_tx_pause_active;
  logic              p1_half_duplex;
  logic [47:0]       pause_src_addr;
  int                mismatches = 0;
  int                checked = 0;
  logic [31:0]       rd_q[$];
  logic [51:0]       out_q[$];
  event              ev_out;
  logic              rd_ph = 1'b0;
  logic              m_bp, m_rx, m_tx, m_man;
  logic [47:0]       m_addr = 48'h0;
  pfc_strap_s        strap;
  logic [31:0]       d;

  assign hready = hreadyout;

  pfc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .strap_pins(strap_pins), .eeprom_load(eeprom_load),
    .eeprom_straps(eeprom_straps), .phy_link_up(phy_link_up),
    .phy_half_duplex(phy_half_duplex), .phy_an_enable(phy_an_enable),
    .phy_an_rx_pause(phy_an_rx_pause), .phy_an_tx_pause(phy_an_tx_pause),
    .p1_backpressure_enable(p1_backpressure_enable),
    .p1_rx_pause_active(p1_rx_pause_active),
    .p1_tx_pause_active(p1_tx_pause_active),
    .p1_half_duplex(p1_half_duplex), .pause_src_addr(pause_src_addr));

  always #2.5 hclk = ~hclk;

  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_port(input logic [51:0] got, input logic [51:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected register image worked out from the mirrored settings.
  function automatic logic [31:0] exp_fc();
    logic h, a, r, t;
    h = phy_link_up ? phy_half_duplex : strap.half_duplex;
    a = phy_link_up ? phy_an_enable : strap.autoneg;
    r = !h && ((m_man || !a) ? m_rx : phy_an_rx_pause);
    t = !h && ((m_man || !a) ? m_tx : phy_an_tx_pause);
    return {25'h0, m_bp, h, r, t, m_rx, m_tx, m_man};
  endfunction

  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, input logic [2:0] sz);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    hsize  <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    xfer(1'b0, a, $urandom, HSIZE_WORD);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [2:0] sz);
    xfer(1'b1, a, v, sz);
    if (sz == HSIZE_WORD) begin
      if (a == FC1_OFF) {m_bp, m_rx, m_tx, m_man} = {v[6], v[2:0]};
      if (a == PAUSE_HI_OFF) m_addr[47:32] = v[15:0];
      if (a == PAUSE_LO_OFF) m_addr[31:0] = v;
    end
  endtask

  task automatic load_cfg(input pfc_strap_s s);
    {m_bp, m_rx, m_tx, m_man} = {s.backpressure, s.fd_pause, s.fd_pause,
                                 s.manual};
  endtask

  // Lets status settle, notes the expected port image, then realigns.
  task automatic settle();
    logic [31:0] f;
    repeat (2) @(posedge hclk);
    #1;
    f = exp_fc();
    out_q.push_back({f[6], f[5], f[4], f[3], m_addr});
    -> ev_out;
    @(posedge hclk);
  endtask

  always @(ev_out)
    cmp_port({p1_backpressure_enable, p1_half_duplex, p1_rx_pause_active,
              p1_tx_pause_active, pause_src_addr},
             out_q.pop_front());

  always @(posedge hclk) begin
    if (!hresetn) begin
      rd_ph = 1'b0;
    end else begin
      if (rd_ph && hready === 1'b1) begin
        cmp_rd(hrdata, rd_q.pop_front());
        cmp_rd({31'h0, hresp}, {31'h0, HRESP_OKAY});
        rd_ph = 1'b0;
      end
      if (hsel && htrans[1] && hready === 1'b1 && !hwrite) rd_ph = 1'b1;
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h7f6f68be));
    strap = pfc_strap_s'($urandom);
    strap_pins <= strap;
    load_cfg(strap);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    settle();
    rd(FC1_OFF, exp_fc());
    rd(PAUSE_HI_OFF, 32'h0);
    phy_link_up <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      phy_half_duplex <= i[2];
      phy_an_enable   <= i[1];
      phy_an_rx_pause <= 1'($urandom);
      phy_an_tx_pause <= 1'($urandom);
      d = $urandom;
      d[0] = i[0];
      wr(FC1_OFF, d, HSIZE_WORD);
      settle();
      rd(FC1_OFF, exp_fc());
    end
    wr(FC1_OFF, ~exp_fc(), 3'h0);
    wr(12'h1a4, 32'hffff_ffff, HSIZE_WORD);
    rd(12'h1a4, 32'h0);
    rd(FC1_OFF, exp_fc());
    wr(PAUSE_HI_OFF, $urandom, HSIZE_WORD);
    wr(PAUSE_LO_OFF, $urandom, HSIZE_WORD);
    settle();
    rd(PAUSE_HI_OFF, {16'h0, m_addr[47:32]});
    rd(PAUSE_LO_OFF, m_addr[31:0]);
    phy_half_duplex <= 1'b0;
    phy_an_enable   <= 1'b1;
    wr(FC1_OFF, 32'h0000_0046, HSIZE_WORD);
    settle();
    wr(FC1_OFF, 32'h0000_0002, HSIZE_WORD);
    rd(FC1_OFF, exp_fc());
    strap = pfc_strap_s'($urandom);
    eeprom_straps <= strap;
    eeprom_load   <= 1'b1;
    @(posedge hclk);
    eeprom_load <= 1'b0;
    load_cfg(strap);
    settle();
    rd(FC1_OFF, exp_fc());
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    strap = strap_pins;
    load_cfg(strap);
    m_addr = 48'h0;
    repeat (6) @(posedge hclk);
    settle();
    rd(FC1_OFF, exp_fc());
    repeat (4) @(posedge hclk);
    complete_run();
  end
endmodule // tb
